// File: tmsc_motion_control.sv
// Motion, direction, brake and unit-select logic for one tape transport.
// Assumes panel and interface pins are asynchronous; registers on a plain port.
//
// What this block does
// - Local forward request sets motion and forward direction.
// - Moving forward: run forward reel motor, drag reverse reel motor.
// - Releasing local request raises hold, clearing motion.
// - Clearing motion while moving fires a 100 ms brake pulse.
// - Brake after forward stop goes to the reverse reel motor.
// - Brake after reverse stop goes to the forward reel motor.
// - Hold while already stopped fires no brake pulse.
// - Stopped and not braking: drag both reel motors.
// - Local reverse request sets motion, clears direction; run reverse motor.
// - Only the select line chosen by the address setting gives a match.
// - Unit selected and head connect are match AND remote mode.
// - Remote control, read and write only while unit is selected, except host halt, which acts in any mode.
// - Head connect energises head relays and lights remote lamp.
// - Remote go sets motion, stop clears it, while selected.
// - Remote forward sets direction, reverse clears it, with go.
// - Host halt clears motion so tape cannot run off.
// - Write echo only when selected and writing is enabled.
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
module tmsc_motion_control #(
  parameter int unsigned BRAKE_CYCLES = tmsc_pkg::BRAKE_CYCLES
) (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  // Register port
  input  wire logic [tmsc_pkg::ADDR_WIDTH-1:0] regAddr,
  input  wire logic [tmsc_pkg::DATA_WIDTH-1:0] regWrData,
  input  wire logic                           regWrite,
  input  wire logic                           regRead,
  output logic      [tmsc_pkg::DATA_WIDTH-1:0] regRdData,
  // Front panel
  input  wire logic                           localForwardReq,
  input  wire logic                           localReverseReq,
  // Controller interface
  input  wire logic [tmsc_pkg::NUM_UNITS-1:0] selectLines,
  input  wire tmsc_pkg::tmsc_cmd_s            remoteCmd,
  input  wire logic                           timingTrack,
  output logic                                writeEcho,
  output logic                                timingPhaseEven,
  output logic                                timingPhaseOdd,
  // Transport side
  output tmsc_pkg::tmsc_motor_s               forwardMotor,
  output tmsc_pkg::tmsc_motor_s               reverseMotor,
  output logic                                headConnect,
  output logic                                remoteIndicator
);
  import tmsc_pkg::*;

  localparam int unsigned SYNC_W = NUM_UNITS + $bits(tmsc_cmd_s) + 3;

  if (BRAKE_CYCLES < 1) begin : g_check
    $error("tmsc_motion_control needs BRAKE_CYCLES of at least one");
  end

  // Control register fields
  logic [2:0]  addressSwitch;
  logic        writeEnable;
  tmsc_mode_e  motionMode;

  // Synchronised pins
  logic [SYNC_W-1:0]    syncBus;
  logic [NUM_UNITS-1:0] selSync;
  tmsc_cmd_s            cmdSync;
  logic                 fwdReqSync;
  logic                 revReqSync;
  logic                 timingSync;
  logic                 timingLast;

  // Motion core
  logic motionActive;
  logic directionFwd;
  logic directionRev;
  logic motionIdle;
  logic brakePulse;
  logic next_motion;
  logic next_direction;
  logic motionClear;
  logic holdRequest;
  logic brakeFire;
  logic isLocal;
  logic isRemote;
  logic addressMatch;
  logic unitSelected;
  logic remoteGo;
  logic remoteStop;

  // Every panel and interface pin crosses two flops before any logic sees it
  tmsc_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .asyncIn ({selectLines, remoteCmd, localForwardReq, localReverseReq, timingTrack}),
    .syncOut (syncBus)
  );

  assign selSync    = syncBus[SYNC_W-1 -: NUM_UNITS];
  assign cmdSync    = syncBus[$bits(tmsc_cmd_s)+2 : 3];
  assign fwdReqSync = syncBus[2];
  assign revReqSync = syncBus[1];
  assign timingSync = syncBus[0];

  // Unit selection
  assign isLocal      = (motionMode == TMSC_MODE_LOCAL);
  assign isRemote     = (motionMode == TMSC_MODE_REMOTE);
  assign addressMatch = selSync[addressSwitch];
  assign unitSelected = addressMatch & isRemote;
  assign headConnect  = unitSelected;
  assign remoteIndicator = headConnect;
  assign writeEcho    = unitSelected & writeEnable;

  // Remote commands count only while selected
  assign remoteGo   = unitSelected & cmdSync.motionGo;
  assign remoteStop = unitSelected & cmdSync.motionStop;

  // Released panel switch sits in the hold position
  assign holdRequest = isLocal & ~fwdReqSync & ~revReqSync;

  // Off mode and the spare code stop the tape like a hold does
  always_comb begin
    motionClear    = 1'b0;
    next_motion    = motionActive;
    next_direction = directionFwd;
    unique case (motionMode)
      TMSC_MODE_LOCAL: begin
        if (fwdReqSync) begin
          next_motion    = 1'b1;
          next_direction = 1'b1;
        end else if (revReqSync) begin
          next_motion    = 1'b1;
          next_direction = 1'b0;
        end else begin
          motionClear = holdRequest;
        end
      end
      TMSC_MODE_REMOTE: begin
        if (remoteStop) begin
          motionClear = 1'b1;
        end else if (remoteGo) begin
          next_motion = 1'b1;
          if (cmdSync.forward) begin
            next_direction = 1'b1;
          end else if (cmdSync.reverse) begin
            next_direction = 1'b0;
          end
        end
      end
      TMSC_MODE_OFF,
      TMSC_MODE_SPARE: begin
        motionClear = 1'b1;
      end
    endcase
    // Halt overrides any mode so a halted host never loses the tape
    if (cmdSync.hostHalt) begin
      motionClear = 1'b1;
    end
    if (motionClear) begin
      next_motion = 1'b0;
    end
  end

  // Brake only when motion was actually running
  assign brakeFire = motionActive & motionClear;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      motionActive <= 1'b0;
    end else begin
      motionActive <= next_motion;
    end
  end

  // Direction is kept after stop so the brake picks the right motor
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      directionFwd <= 1'b1;
    end else begin
      directionFwd <= next_direction;
    end
  end

  assign directionRev = ~directionFwd;
  assign motionIdle   = ~motionActive;

  // New motion cancels a brake still running
  tmsc_brake_timer #(
    .CYCLES (BRAKE_CYCLES)
  ) u_brake (
    .clk     (clk),
    .reset_n (reset_n),
    .fire    (brakeFire),
    .cancel  (motionActive),
    .active  (brakePulse)
  );

  // Reel motor decode
  always_comb begin
    forwardMotor.run   = motionActive & directionFwd;
    reverseMotor.drag  = (motionActive & directionFwd)
                       | (motionIdle & ~brakePulse);
    reverseMotor.run   = motionActive & directionRev;
    forwardMotor.drag  = (motionActive & directionRev)
                       | (motionIdle & ~brakePulse);
    reverseMotor.brake = brakePulse & motionIdle & directionFwd;
    forwardMotor.brake = brakePulse & motionIdle & directionRev;
  end

  // Timing track relayed as phase pulses only while the head is connected
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timingLast <= 1'b0;
    end else begin
      timingLast <= timingSync;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timingPhaseEven <= 1'b0;
      timingPhaseOdd  <= 1'b0;
    end else begin
      timingPhaseEven <= headConnect & timingSync & ~timingLast;
      timingPhaseOdd  <= headConnect & ~timingSync & timingLast;
    end
  end

  // Register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addressSwitch <= CTRL_ADDR_RESET;
      writeEnable   <= CTRL_WREN_RESET;
      motionMode    <= CTRL_MODE_RESET;
    end else if (regWrite && regAddr == CTRL_OFFSET) begin
      addressSwitch <= regWrData[CTRL_ADDR_LSB +: 3];
      writeEnable   <= regWrData[CTRL_WREN_BIT];
      motionMode    <= tmsc_mode_e'(regWrData[CTRL_MODE_LSB +: 2]);
    end
  end

  // Register reads, data valid the cycle after the strobe only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= '0;
    end else begin
      regRdData <= '0;
      if (regRead && regAddr == CTRL_OFFSET) begin
        regRdData[CTRL_ADDR_LSB +: 3] <= addressSwitch;
        regRdData[CTRL_WREN_BIT]      <= writeEnable;
        regRdData[CTRL_MODE_LSB +: 2] <= motionMode;
      end else if (regRead && regAddr == STATUS_OFFSET) begin
        regRdData[STAT_MOTION_BIT] <= motionActive;
        regRdData[STAT_DIR_BIT]    <= directionFwd;
        regRdData[STAT_BRAKE_BIT]  <= brakePulse;
        regRdData[STAT_MATCH_BIT]  <= addressMatch;
        regRdData[STAT_SEL_BIT]    <= unitSelected;
        regRdData[STAT_ECHO_BIT]   <= writeEcho;
        regRdData[STAT_HALT_BIT]   <= cmdSync.hostHalt;
      end
    end
  end

  // Checks
  property p_local_fwd;
    @(posedge clk) disable iff (!reset_n)
    (isLocal && fwdReqSync && !cmdSync.hostHalt) |=> (motionActive && directionFwd);
  endproperty
  a_local_fwd: assert property (p_local_fwd)
    else $error("Local forward did not start forward motion");

  property p_run_fwd;
    @(posedge clk) disable iff (!reset_n)
    (motionActive && directionFwd) |-> (forwardMotor.run && reverseMotor.drag
                                         && !reverseMotor.run && !forwardMotor.drag);
  endproperty
  a_run_fwd: assert property (p_run_fwd)
    else $error("Forward motion motor commands wrong");

  property p_hold;
    @(posedge clk) disable iff (!reset_n)
    holdRequest |=> !motionActive;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Hold did not stop motion");

  property p_brake_fire;
    @(posedge clk) disable iff (!reset_n)
    (motionActive && motionClear) |=> (brakePulse && !motionActive);
  endproperty
  a_brake_fire: assert property (p_brake_fire)
    else $error("Stopping a moving tape fired no brake");

  property p_brake_rev_motor;
    @(posedge clk) disable iff (!reset_n)
    ($past(motionActive) && $past(directionFwd) && !motionActive && brakePulse)
      |-> (reverseMotor.brake && !forwardMotor.brake && !reverseMotor.drag);
  endproperty
  a_brake_rev_motor: assert property (p_brake_rev_motor)
    else $error("Forward stop did not brake reverse motor");

  property p_brake_fwd_motor;
    @(posedge clk) disable iff (!reset_n)
    ($past(motionActive) && !$past(directionFwd) && !motionActive && brakePulse)
      |-> (forwardMotor.brake && !reverseMotor.brake && !forwardMotor.drag);
  endproperty
  a_brake_fwd_motor: assert property (p_brake_fwd_motor)
    else $error("Reverse stop did not brake forward motor");

  property p_no_brake_idle;
    @(posedge clk) disable iff (!reset_n)
    (!motionActive && !brakePulse && motionClear) |=> !brakePulse;
  endproperty
  a_no_brake_idle: assert property (p_no_brake_idle)
    else $error("Brake fired while already stopped");

  property p_drag_both;
    @(posedge clk) disable iff (!reset_n)
    (!motionActive && !brakePulse) |-> (forwardMotor.drag && reverseMotor.drag
                                        && !forwardMotor.run && !reverseMotor.run);
  endproperty
  a_drag_both: assert property (p_drag_both)
    else $error("Idle tape lost tension drag");

  property p_local_rev;
    @(posedge clk) disable iff (!reset_n)
    (isLocal && revReqSync && !fwdReqSync && !cmdSync.hostHalt)
      |=> (motionActive && !directionFwd && reverseMotor.run && forwardMotor.drag);
  endproperty
  a_local_rev: assert property (p_local_rev)
    else $error("Local reverse did not start reverse motion");

  property p_select;
    @(posedge clk) disable iff (!reset_n)
    headConnect |-> (isRemote && selSync[addressSwitch] && remoteIndicator);
  endproperty
  a_select: assert property (p_select)
    else $error("Head connected without remote selection");

  property p_unselected_go;
    @(posedge clk) disable iff (!reset_n)
    (!motionActive && !unitSelected && isRemote) |=> !motionActive;
  endproperty
  a_unselected_go: assert property (p_unselected_go)
    else $error("Motion started while not selected");

  property p_halt;
    @(posedge clk) disable iff (!reset_n)
    cmdSync.hostHalt |=> !motionActive;
  endproperty
  a_halt: assert property (p_halt)
    else $error("Host halt did not stop tape");

  property p_write_echo;
    @(posedge clk) disable iff (!reset_n)
    writeEcho |-> (unitSelected && writeEnable);
  endproperty
  a_write_echo: assert property (p_write_echo)
    else $error("Write echo without selection and enable");

endmodule

// File: tmsc_pkg.sv
// Package for the tape motion and unit-select control block.
// Assumes a single 100 MHz system clock; no other sharing.
package tmsc_pkg;

  localparam int unsigned CLK_FREQ_HZ   = 100_000_000;
  localparam int unsigned BRAKE_TIME_MS = 100;
  localparam int unsigned BRAKE_CYCLES  = BRAKE_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned SYNC_STAGES   = 2;

  localparam int unsigned NUM_UNITS  = 8;
  localparam int unsigned ADDR_WIDTH = 4;
  localparam int unsigned DATA_WIDTH = 32;

  // Register byte offsets
  localparam logic [3:0] CTRL_OFFSET   = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;

  // Control register fields
  localparam int unsigned CTRL_ADDR_LSB = 0;
  localparam int unsigned CTRL_WREN_BIT = 3;
  localparam int unsigned CTRL_MODE_LSB = 4;

  // Status register fields
  localparam int unsigned STAT_MOTION_BIT = 0;
  localparam int unsigned STAT_DIR_BIT    = 1;
  localparam int unsigned STAT_BRAKE_BIT  = 2;
  localparam int unsigned STAT_MATCH_BIT  = 3;
  localparam int unsigned STAT_SEL_BIT    = 4;
  localparam int unsigned STAT_ECHO_BIT   = 5;
  localparam int unsigned STAT_HALT_BIT   = 6;

  typedef enum logic [1:0] {
    TMSC_MODE_OFF,
    TMSC_MODE_LOCAL,
    TMSC_MODE_REMOTE,
    TMSC_MODE_SPARE
  } tmsc_mode_e;

  localparam logic [2:0] CTRL_ADDR_RESET = 3'h0;
  localparam logic       CTRL_WREN_RESET = 1'b0;
  localparam tmsc_mode_e CTRL_MODE_RESET = TMSC_MODE_OFF;

  // Remote command lines from the controller
  typedef struct packed {
    logic motionGo;
    logic motionStop;
    logic forward;
    logic reverse;
    logic hostHalt;
  } tmsc_cmd_s;

  // Commands to one reel motor
  typedef struct packed {
    logic run;
    logic drag;
    logic brake;
  } tmsc_motor_s;

endpackage

// File: tmsc_sync.sv
// Two-flop synchroniser for a vector of unrelated levels.
// Assumes each bit is a slow level; no bus coherency is offered.
`timescale 1ns/1ps
module tmsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);
  import tmsc_pkg::*;

  logic [WIDTH-1:0] stage1;

  if (WIDTH < 1) begin : g_check
    $error("tmsc_sync needs WIDTH of at least one");
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1  <= '0;
      syncOut <= '0;
    end else begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule

// File: tmsc_brake_timer.sv
// Retriggerable counter one-shot for the reel brake pulse.
// Assumes fire and cancel come from logic on the same clock.
`timescale 1ns/1ps
module tmsc_brake_timer #(
  parameter int unsigned CYCLES = tmsc_pkg::BRAKE_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic fire,
  input  wire logic cancel,
  output logic      active
);
  import tmsc_pkg::*;

  localparam int unsigned CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES);

  logic [CW-1:0] remaining;

  if (CYCLES < 1) begin : g_check
    $error("tmsc_brake_timer needs CYCLES of at least one");
  end

  // Fire wins over cancel so a stop event is never lost
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      remaining <= '0;
    end else if (fire) begin
      remaining <= LOAD;
    end else if (cancel) begin
      remaining <= '0;
    end else if (remaining != '0) begin
      remaining <= remaining - CW'(1);
    end
  end

  assign active = (remaining != '0);

  property p_brake_length;
    @(posedge clk) disable iff (!reset_n)
    fire |=> (remaining == LOAD);
  endproperty
  a_brake_length: assert property (p_brake_length)
    else $error("Brake pulse not loaded with its full length");

endmodule

// File: tmsc_ctrl_model.sv
// Controller model: select lines, command levels and timing track.
// Assumes request inputs change just after clk edges; track runs only in frames.
`timescale 1ns/1ps
module tmsc_ctrl_model (
  input  wire logic          clk,
  input  wire logic          selOn,
  input  wire logic [2:0]    selUnit,
  input  wire logic          goReq,
  input  wire logic          fwdReq,
  input  wire logic          haltReq,
  input  wire logic          frameOn,
  input  wire logic          otherEcho,
  input  wire logic          headConnect,
  input  wire logic          timingPhaseEven,
  input  wire logic          timingPhaseOdd,
  output logic [7:0]         selectLines,
  output tmsc_pkg::tmsc_cmd_s remoteCmd,
  output logic               timingTrack,
  output logic               selectError,
  output int                 riseCount,
  output int                 fallCount,
  output int                 evenCount,
  output int                 oddCount,
  output int                 wordCount,
  output int                 modelErr,
  output logic               writeBuf
);
  import tmsc_pkg::*;
  localparam int FRAME_BITS  = 3;
  localparam int CTRL_FRAMES = 6;
  // Arbitrary mark patterns, each equal to itself reversed and inverted
  localparam logic [5:0] MARK_CODES [4] = '{6'h19, 6'h2a, 6'h34, 6'h07};
  logic nextData = 1'b1;
  logic lastBit  = 1'b0;
  logic loaded   = 1'b0;
  int   bitCount = 0;
  int   seqErr   = 0;
  int   markErr  = 0;

  assign selectLines = selOn ? (8'h01 << selUnit) : 8'h00;
  // Stop is always the complement of go; reverse is the complement of forward only while go is high
  assign remoteCmd = '{motionGo: goReq, motionStop: !goReq, forward: goReq && fwdReq,
                       reverse: goReq && !fwdReq, hostHalt: haltReq};
  // No echo or two echoes on one select line is an error
  assign selectError = selOn && (headConnect == otherEcho);
  assign modelErr    = markErr + seqErr;

  function automatic logic [5:0] mark_read(input logic [5:0] c, input logic rev);
    mark_read = c;
    for (int k = 0; k < 6; k++) begin
      if (rev) mark_read[k] = !c[5-k];
    end
  endfunction

  initial begin
    for (int i = 0; i < 4; i++) begin
      if (mark_read(MARK_CODES[i], 1'b1) != MARK_CODES[i]) markErr++;
      for (int j = i + 1; j < 4; j++) begin
        if ($countones(MARK_CODES[i] ^ MARK_CODES[j]) < 2) markErr++;
      end
    end
  end

  // Odd start offset keeps track edges off clk edges, each one 2 ns before a rising clk edge
  initial begin
    timingTrack = 1'b0;
    #3;
    forever begin
      #40;
      if (frameOn) begin
        timingTrack = !timingTrack;
        if (timingTrack) riseCount++;
        else fallCount++;
      end
    end
  end

  always @(posedge clk) begin
    // Complement is loaded so the odd reversal leaves the written bit
    if (timingPhaseEven) begin
      writeBuf <= !nextData;
      lastBit <= nextData;
      nextData <= !nextData;
      evenCount <= evenCount + 1;
      if (loaded) seqErr <= seqErr + 1;
      loaded <= 1'b1;
    end
    // Odd phase reverses write current and is also the read sample point
    if (timingPhaseOdd) begin
      writeBuf <= !writeBuf;
      oddCount <= oddCount + 1;
      if (!loaded || writeBuf == lastBit) seqErr <= seqErr + 1;
      loaded <= 1'b0;
      bitCount <= bitCount + 1;
      if ((bitCount + 1) % (FRAME_BITS * CTRL_FRAMES) == 0) begin
        wordCount <= wordCount + 1;
      end
    end
  end
endmodule

// File: tape_motion_select_control_tb_top.sv
// Self-checking bench for the tape motion and unit-select control.
// Assumes tmsc_ctrl_model on the far side; brake shortened to 20 cycles.
`timescale 1ns/1ps
module tape_motion_select_control_tb_top;
  import tmsc_pkg::*;
  localparam int BRK = 20;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic [31:0] regRdData;
  logic        localForwardReq = 1'b0;
  logic        localReverseReq = 1'b0;
  logic        selOn = 1'b0;
  logic [2:0]  selUnit = 3'h0;
  logic        goReq = 1'b0;
  logic        fwdReq = 1'b0;
  logic        haltReq = 1'b0;
  logic        frameOn = 1'b0;
  logic [7:0]  selectLines;
  tmsc_cmd_s   remoteCmd;
  logic        timingTrack, writeEcho, timingPhaseEven, timingPhaseOdd;
  logic        headConnect, remoteIndicator, writeBuf, rdPend = 1'b0;
  logic        otherEcho = 1'b0, selectError;
  tmsc_motor_s forwardMotor, reverseMotor;
  int          riseCount, fallCount, evenCount, oddCount, e0, wordCount, modelErr;
  int          err_count = 0;
  int          comparisons = 0;
  logic [31:0] seed = 32'h6df8;
  logic [31:0] expQ[$];
  logic [31:0] r;
  logic [2:0]  u;

  always #5 clk = ~clk;

  tmsc_motion_control #(.BRAKE_CYCLES(BRK)) tmsc_motion_control_i (
    .clk(clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .localForwardReq(localForwardReq), .localReverseReq(localReverseReq),
    .selectLines(selectLines), .remoteCmd(remoteCmd), .timingTrack(timingTrack),
    .writeEcho(writeEcho), .timingPhaseEven(timingPhaseEven),
    .timingPhaseOdd(timingPhaseOdd), .forwardMotor(forwardMotor),
    .reverseMotor(reverseMotor), .headConnect(headConnect),
    .remoteIndicator(remoteIndicator));

  tmsc_ctrl_model tmsc_ctrl_model_i (
    .clk(clk), .selOn(selOn), .selUnit(selUnit), .goReq(goReq), .fwdReq(fwdReq),
    .haltReq(haltReq), .frameOn(frameOn), .otherEcho(otherEcho),
    .headConnect(headConnect), .timingPhaseEven(timingPhaseEven),
    .timingPhaseOdd(timingPhaseOdd), .selectLines(selectLines), .remoteCmd(remoteCmd),
    .timingTrack(timingTrack), .selectError(selectError), .riseCount(riseCount),
    .fallCount(fallCount), .evenCount(evenCount), .oddCount(oddCount),
    .wordCount(wordCount), .modelErr(modelErr), .writeBuf(writeBuf));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic mot(input logic [5:0] e);
    chk({26'h0, forwardMotor, reverseMotor}, {26'h0, e});
  endtask

  // Upper data bits are random; the block must ignore them
  task automatic wr(input logic [3:0] a, input logic [5:0] f);
    r = rnd();
    @(posedge clk);
    regAddr <= a;
    regWrData <= {r[31:6], f};
    regWrite <= 1'b1;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRead <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regRead <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clk) begin
    if (rdPend) chk(regRdData, expQ.pop_front());
    rdPend <= regRead;
  end

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #200_000;
    err_count++;
    test_done();
  end

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wt(1);
    mot(6'h12);
    rd(4'h0, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'h4, 32'h2);
    $display("reset test done");
    wr(4'h0, 6'h10);
    localForwardReq <= 1'b1;
    wt(6);
    mot(6'h22);
    rd(4'h4, 32'h3);
    localForwardReq <= 1'b0;
    wt(6);
    mot(6'h01);
    rd(4'h4, 32'h6);
    wt(BRK);
    mot(6'h12);
    wr(4'h0, 6'h00);
    wt(6);
    mot(6'h12);
    wr(4'h0, 6'h10);
    localReverseReq <= 1'b1;
    wt(6);
    mot(6'h14);
    localReverseReq <= 1'b0;
    wt(6);
    mot(6'h08);
    // Reset in mid-brake must cancel the pulse and restore drag
    reset_n <= 1'b0;
    wt(2);
    mot(6'h12);
    reset_n <= 1'b1;
    wt(2);
    mot(6'h12);
    rd(4'h4, 32'h2);
    $display("local test done");
    for (int a = 0; a < 8; a++) begin
      wr(4'h0, {3'b101, a[2:0]});
      r = rnd();
      u = a[2:0] ^ (r[2:0] | 3'h1);
      selOn <= 1'b1;
      selUnit <= u;
      wt(5);
      chk({30'h0, headConnect, writeEcho}, 32'h0);
      chk({31'h0, selectError}, 32'h1);
      selUnit <= a[2:0];
      wt(5);
      chk({29'h0, headConnect, remoteIndicator, writeEcho}, 32'h7);
      chk({31'h0, selectError}, 32'h0);
    end
    otherEcho <= 1'b1;
    wt(2);
    chk({31'h0, selectError}, 32'h1);
    otherEcho <= 1'b0;
    wr(4'h0, 6'h27);
    wt(5);
    chk({31'h0, writeEcho}, 32'h0);
    rd(4'h0, 32'h27);
    $display("select test done");
    goReq <= 1'b1;
    fwdReq <= 1'b1;
    wt(6);
    mot(6'h22);
    fwdReq <= 1'b0;
    wt(6);
    mot(6'h14);
    goReq <= 1'b0;
    wt(6);
    mot(6'h08);
    wt(BRK);
    selOn <= 1'b0;
    goReq <= 1'b1;
    fwdReq <= 1'b1;
    wt(6);
    mot(6'h12);
    selOn <= 1'b1;
    wt(6);
    mot(6'h22);
    haltReq <= 1'b1;
    wt(6);
    mot(6'h01);
    rd(4'h4, 32'h5e);
    haltReq <= 1'b0;
    goReq <= 1'b0;
    wt(BRK + 5);
    $display("remote test done");
    frameOn <= 1'b1;
    wt(400);
    frameOn <= 1'b0;
    wt(10);
    chk(32'(riseCount > 4), 32'h1);
    chk(evenCount, riseCount);
    chk(oddCount, fallCount);
    chk(modelErr, 0);
    chk(wordCount, oddCount / (6 * 3));
    chk(32'(oddCount >= 4 * 3), 32'h1);
    e0 = evenCount + oddCount;
    selOn <= 1'b0;
    frameOn <= 1'b1;
    wt(30);
    frameOn <= 1'b0;
    wt(10);
    chk(evenCount + oddCount, e0);
    $display("timing test done");
    test_done();
  end
endmodule
